// ### logic/cbs_pkg.sv
// Constants, register map and state type for the buffer state control block
package cbs_pkg;
	// Register byte offsets on the control bus
	localparam logic [7:0]  OFS_REQ       = 8'h00;
	localparam logic [7:0]  OFS_STS       = 8'h04;
	localparam logic [7:0]  OFS_CANCEL    = 8'h08;
	localparam logic [7:0]  OFS_START     = 8'h0C;
	localparam logic [7:0]  OFS_INTF_ID   = 8'h10;
	localparam int          ADDR_W        = 8;

	// Field positions
	localparam int          REQ_READY_BIT = 0;
	localparam int          REQ_IDLE_BIT  = 1;
	localparam int          STS_FATAL_BIT = 0;
	localparam int          STS_IDLE_BIT  = 1;
	localparam int          ID_BYPASS_BIT = 0;

	// Values and reset values
	localparam logic [31:0] REG_ZERO      = 32'h0000_0000;
	localparam logic [31:0] CANCEL_ON     = 32'h0000_0001;
	localparam logic [31:0] START_GO      = 32'h0000_0001;
	localparam logic [31:0] STS_IDLE_LOAD = 32'h0000_0002;

	// Bus responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_DECERR   = 2'h3;

	// Timing: clock period and timeouts
	localparam int          CLK_PERIOD_NS = 5;
	localparam int          TIMEOUT_B_NS  = 2000000;
	localparam int          TIMEOUT_C_NS  = 200000;
	localparam int          TIMEOUT_D_NS  = 30000000;
	localparam int          CANCEL_CYC    = TIMEOUT_B_NS / CLK_PERIOD_NS;
	localparam int          STATE_CHG_CYC = TIMEOUT_C_NS / CLK_PERIOD_NS;
	localparam int          POST_INIT_CYC = TIMEOUT_D_NS / CLK_PERIOD_NS;
	localparam int          CNT_W         = 32;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READY,
		ST_RECEPTION,
		ST_EXECUTION,
		ST_COMPLETION
	} cbs_state_t;
endpackage : cbs_pkg

// ### logic/cbs_ctrl.sv
// Command/response buffer state control with an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Without bypass, writing ready request 1 moves Idle to Ready.
// - Accepted ready request bit clears itself quickly; zero writes do nothing.
// - With bypass capable, ready request in Completion goes straight to Ready.
// - Request and status bits read valid right after the init event.
// - Idle request invalidates buffer, enters Idle, sets idle flag, self-clears.
// - A placed response stays intact until an idle request, locality change or seize arrives.
// - Idle request: invalidate buffer, status becomes 0002h, then request 0000h.
// - All request register writes are ignored during Execution.
// - Status bits 31:2 read zero; status register is read only.
// - Idle flag is 1 exactly while in Idle.
// - Device leaves initialization in Idle with idle flag set.
// - Ready request clears idle flag and reaches Ready within the timeout.
// - Fatal flag set only by unreportable fatal error; zero when operational.
// - Cancel of 0001h in Execution ends command; response then Completion.
// - Cancel finishes or abandons within cancel timeout and clears start.
// - Cancel value is disregarded outside Execution.
// - Cancel is a 32-bit read/write register that reads back its value.
// - Seize during Execution acts as cancel, followed by Idle.
// - Start write of 0001h in Reception begins execution; otherwise ignored.
// - Idle after initialization and after a locality change outside Execution.
module cbs_ctrl
	import cbs_pkg::*;
#(
	parameter int          CANCEL_CYCLES       = cbs_pkg::CANCEL_CYC,
	parameter logic        IDLE_BYPASS_CAPABLE = 1'b0
) (
	input  wire logic                     aclk,              // 200 MHz clock
	input  wire logic                     aresetn,           // Sync reset, active low
	input  wire logic [cbs_pkg::ADDR_W-1:0] s_axi_awaddr,   // Write address
	input  wire logic                     s_axi_awvalid,     // Write address valid
	output logic                          s_axi_awready,     // Write address ready
	input  wire logic [31:0]              s_axi_wdata,       // Write data
	input  wire logic [3:0]               s_axi_wstrb,       // Write byte strobes
	input  wire logic                     s_axi_wvalid,      // Write data valid
	output logic                          s_axi_wready,      // Write data ready
	output logic [1:0]                    s_axi_bresp,       // Write response
	output logic                          s_axi_bvalid,      // Write response valid
	input  wire logic                     s_axi_bready,      // Write response ready
	input  wire logic [cbs_pkg::ADDR_W-1:0] s_axi_araddr,   // Read address
	input  wire logic                     s_axi_arvalid,     // Read address valid
	output logic                          s_axi_arready,     // Read address ready
	output logic [31:0]                   s_axi_rdata,       // Read data
	output logic [1:0]                    s_axi_rresp,       // Read response
	output logic                          s_axi_rvalid,      // Read data valid
	input  wire logic                     s_axi_rready,      // Read data ready
	input  wire logic                     init_event,        // Init pulse, restarts in Idle
	input  wire logic                     locality_change,   // Locality change pulse
	input  wire logic                     seize,             // Seize request pulse
	input  wire logic                     cmd_write_seen,    // First command byte written
	input  wire logic                     exec_done,         // Engine finished command
	input  wire logic                     exec_canceled,     // Engine terminated it
	input  wire logic                     fatal_error,       // Unreportable fatal error
	output logic                          exec_start,        // Begin execution pulse
	output logic                          exec_cancel,       // Cancel request level
	output logic                          buf_invalidate,    // Drop buffer contents pulse
	output logic                          resp_canceled,     // Response is canceled code
	output cbs_pkg::cbs_state_t           state              // Current interface state
);
	import cbs_pkg::*;

	cbs_state_t          state_q;
	logic                aw_q;
	logic                w_q;
	logic [ADDR_W-1:0]   awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                rvalid_q;
	logic [31:0]         rdata_q;
	logic [1:0]          rresp_q;
	logic                ready_req_q;
	logic                idle_req_q;
	logic                idle_ack_q;
	logic                fatal_q;
	logic [31:0]         cancel_q;
	logic [31:0]         start_q;
	logic                seize_pend_q;
	logic [CNT_W-1:0]    cancel_cnt_q;
	logic                exec_start_q;
	logic                exec_cancel_q;
	logic                buf_inv_q;
	logic                resp_canceled_q;

	logic                do_write;
	logic                wr_req;
	logic                wr_cancel;
	logic                wr_start;
	logic                mapped_w;
	logic                mapped_r;
	logic                in_exec;
	logic                idle_go;
	logic                ready_go;
	logic                start_hit;
	logic                cancel_act;
	logic                abandon;
	logic                finish;
	logic                ext_idle;
	logic [31:0]         sts_val;
	logic [31:0]         rd_mux;

	// Apply byte strobes to a 32-bit register
	function automatic logic [31:0] strobe_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : strobe_merge

	// Bus slave: address and data are taken in either order, answered together
	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready  = !w_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	assign do_write  = aw_q && w_q && !bvalid_q;
	assign in_exec   = (state_q == ST_EXECUTION);
	assign wr_req    = do_write && (awaddr_q == OFS_REQ) && wstrb_q[0] && !in_exec;
	assign wr_cancel = do_write && (awaddr_q == OFS_CANCEL);
	assign wr_start  = do_write && (awaddr_q == OFS_START);
	assign mapped_w  = (awaddr_q == OFS_REQ) || (awaddr_q == OFS_STS) ||
		(awaddr_q == OFS_CANCEL) || (awaddr_q == OFS_START) || (awaddr_q == OFS_INTF_ID);
	assign mapped_r  = (s_axi_araddr == OFS_REQ) || (s_axi_araddr == OFS_STS) ||
		(s_axi_araddr == OFS_CANCEL) || (s_axi_araddr == OFS_START) ||
		(s_axi_araddr == OFS_INTF_ID);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q     <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_q     <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (do_write) begin
			aw_q     <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_q     <= 1'b0;
			wdata_q <= REG_ZERO;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_q     <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_q     <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= mapped_w ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Status is built live from state, so reads are valid from the first cycle
	always_comb begin
		sts_val                = REG_ZERO;
		sts_val[STS_IDLE_BIT]  = (state_q == ST_IDLE);
		sts_val[STS_FATAL_BIT] = fatal_q;
	end

	always_comb begin
		rd_mux = REG_ZERO;
		case (s_axi_araddr)
			OFS_REQ: begin
				rd_mux[REQ_READY_BIT] = ready_req_q;
				rd_mux[REQ_IDLE_BIT]  = idle_req_q;
			end
			OFS_STS:     rd_mux = sts_val;
			OFS_CANCEL:  rd_mux = cancel_q;
			OFS_START:   rd_mux = start_q;
			OFS_INTF_ID: rd_mux[ID_BYPASS_BIT] = IDLE_BYPASS_CAPABLE;
			default:     rd_mux = REG_ZERO;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= REG_ZERO;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= mapped_r ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Request decode, qualified by state
	assign ext_idle  = (locality_change || seize) && !in_exec;
	assign idle_go   = (idle_req_q && !idle_ack_q && (state_q == ST_READY ||
		state_q == ST_RECEPTION || state_q == ST_COMPLETION)) || ext_idle;
	assign ready_go  = ready_req_q && !idle_req_q;
	assign start_hit = wr_start && (wdata_q == START_GO) && (state_q == ST_RECEPTION);
	assign cancel_act = in_exec && ((cancel_q == CANCEL_ON) || seize_pend_q);
	assign abandon   = cancel_act && (cancel_cnt_q == CNT_W'(CANCEL_CYCLES - 1));
	assign finish    = in_exec && (exec_done || abandon);

	// Interface state machine
	always_ff @(posedge aclk) begin
		if (!aresetn || init_event) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (ready_go) begin
						state_q <= ST_READY;
					end
				end
				ST_READY: begin
					if (idle_go) begin
						state_q <= ST_IDLE;
					end else if (cmd_write_seen) begin
						state_q <= ST_RECEPTION;
					end
				end
				ST_RECEPTION: begin
					if (idle_go) begin
						state_q <= ST_IDLE;
					end else if (start_hit) begin
						state_q <= ST_EXECUTION;
					end
				end
				ST_EXECUTION: begin
					if (finish) begin
						// A seize in the finishing cycle still wins
						state_q <= (seize_pend_q || seize) ? ST_IDLE : ST_COMPLETION;
					end
				end
				ST_COMPLETION: begin
					if (idle_go) begin
						state_q <= ST_IDLE;
					end else if (ready_go && IDLE_BYPASS_CAPABLE) begin
						state_q <= ST_READY;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Request bits: a new write of 1 wins over the self-clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn || init_event) begin
			ready_req_q <= 1'b0;
		end else if (wr_req && wdata_q[REQ_READY_BIT]) begin
			ready_req_q <= 1'b1;
		end else if (idle_ack_q || ready_go) begin
			ready_req_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || init_event) begin
			idle_req_q <= 1'b0;
		end else if (wr_req && wdata_q[REQ_IDLE_BIT]) begin
			idle_req_q <= 1'b1;
		end else if (idle_ack_q || (idle_req_q && state_q == ST_IDLE)) begin
			idle_req_q <= 1'b0;
		end
	end

	// Request clears one cycle after the buffer drop and status load
	always_ff @(posedge aclk) begin
		if (!aresetn || init_event) begin
			idle_ack_q <= 1'b0;
		end else begin
			idle_ack_q <= idle_go && idle_req_q;
		end
	end

	// Fatal flag: a new fault wins over the idle status load
	always_ff @(posedge aclk) begin
		if (!aresetn || init_event) begin
			fatal_q <= 1'b0;
		end else if (fatal_error) begin
			fatal_q <= 1'b1;
		end else if (idle_go) begin
			fatal_q <= STS_IDLE_LOAD[STS_FATAL_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || init_event) begin
			cancel_q <= REG_ZERO;
		end else if (wr_cancel) begin
			cancel_q <= strobe_merge(cancel_q, wdata_q, wstrb_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || init_event) begin
			start_q <= REG_ZERO;
		end else if (start_hit) begin
			start_q <= START_GO;
		end else if (finish) begin
			start_q <= REG_ZERO;
		end
	end

	// Seize during execution is held until the command ends
	always_ff @(posedge aclk) begin
		if (!aresetn || init_event) begin
			seize_pend_q <= 1'b0;
		end else if (seize && in_exec && !finish) begin
			seize_pend_q <= 1'b1;
		end else if (!in_exec || finish) begin
			seize_pend_q <= 1'b0;
		end
	end

	// Cancel watchdog: the command is abandoned if the engine does not end it in time
	always_ff @(posedge aclk) begin
		if (!aresetn || !cancel_act || finish) begin
			cancel_cnt_q <= '0;
		end else begin
			cancel_cnt_q <= cancel_cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || init_event) begin
			exec_start_q    <= 1'b0;
			exec_cancel_q   <= 1'b0;
			buf_inv_q       <= 1'b0;
			resp_canceled_q <= 1'b0;
		end else begin
			exec_start_q  <= start_hit;
			exec_cancel_q <= cancel_act && !finish;
			buf_inv_q     <= idle_go || (finish && (seize_pend_q || seize));
			if (start_hit) begin
				resp_canceled_q <= 1'b0;
			end else if (finish) begin
				// A seized command ends in Idle with its buffer dropped, so no code is shown
				resp_canceled_q <= !(seize_pend_q || seize) &&
					(abandon || (exec_done && exec_canceled));
			end
		end
	end

	assign exec_start     = exec_start_q;
	assign exec_cancel    = exec_cancel_q;
	assign buf_invalidate = buf_inv_q;
	assign resp_canceled  = resp_canceled_q;
	assign state          = state_q;
endmodule : cbs_ctrl

`default_nettype wire

// ### tb/cbs_monitor.sv
// Port checker for the buffer state control block
`timescale 1ns/100ps
`default_nettype none
module cbs_monitor
	import cbs_pkg::*;
#(
	parameter int CANCEL_CYCLES = 16
) (
	input wire logic                aclk,            // Clock
	input wire logic                aresetn,         // Sync reset, active low
	input wire logic                init_event,      // Init pulse
	input wire logic                locality_change, // Locality change pulse
	input wire logic                seize,           // Seize pulse
	input wire logic                exec_start,      // Begin execution pulse
	input wire logic                exec_cancel,     // Cancel level to engine
	input wire logic                buf_invalidate,  // Buffer drop pulse
	input wire logic                resp_canceled,   // Canceled response level
	input wire cbs_pkg::cbs_state_t state            // Interface state
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Counts cycles of a pending cancel; a stuck engine must still be abandoned
	logic [31:0] cnc_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || !exec_cancel)
			cnc_q <= 32'h0;
		else
			cnc_q <= cnc_q + 32'h1;
	end

	enter_exec_a: assert property ((state == ST_EXECUTION && $past(state) != ST_EXECUTION)
		|-> $past(state) == ST_RECEPTION) else $error("execution entered from wrong state");
	start_pulse_a: assert property (exec_start |-> state == ST_EXECUTION ##1 !exec_start)
		else $error("start pulse malformed");
	cancel_scope_a: assert property (exec_cancel |-> $past(state) == ST_EXECUTION)
		else $error("cancel outside execution");
	exec_exit_a: assert property ((state == ST_EXECUTION ##1 state != ST_EXECUTION)
		|-> state inside {ST_COMPLETION, ST_IDLE}) else $error("bad exit from execution");
	init_idle_a: assert property (init_event |=> state == ST_IDLE)
		else $error("init did not reach idle");
	loc_idle_a: assert property (locality_change && state != ST_EXECUTION
		|=> state == ST_IDLE ##[0:1] buf_invalidate) else $error("locality change missed");
	inval_idle_a: assert property (buf_invalidate |-> state == ST_IDLE)
		else $error("invalidate outside idle");
	canceled_done_a: assert property ($rose(resp_canceled) |-> state == ST_COMPLETION)
		else $error("canceled code without completion");
	cancel_bound_a: assert property (cnc_q <= CANCEL_CYCLES + 4)
		else $error("cancel not finished in time");
	seize_cancel_a: assert property (seize && state == ST_EXECUTION
		|=> ##1 (exec_cancel || state == ST_IDLE)) else $error("seize not treated as cancel");
endmodule : cbs_monitor
`default_nettype wire

// ### tb/cbs_host.sv
// Host software model: register bus master for the control area
`timescale 1ns/100ps
`default_nettype none
module cbs_host (
	input wire logic        aclk,          // Clock
	output var logic [7:0]  s_axi_awaddr,  // Write address
	output var logic        s_axi_awvalid, // Write address valid
	input wire logic        s_axi_awready, // Write address ready
	output var logic [31:0] s_axi_wdata,   // Write data
	output var logic [3:0]  s_axi_wstrb,   // Byte strobes
	output var logic        s_axi_wvalid,  // Write data valid
	input wire logic        s_axi_wready,  // Write data ready
	input wire logic [1:0]  s_axi_bresp,   // Write response
	input wire logic        s_axi_bvalid,  // Write response valid
	output var logic        s_axi_bready,  // Write response ready
	output var logic [7:0]  s_axi_araddr,  // Read address
	output var logic        s_axi_arvalid, // Read address valid
	input wire logic        s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata,   // Read data
	input wire logic [1:0]  s_axi_rresp,   // Read response
	input wire logic        s_axi_rvalid,  // Read valid
	output var logic        s_axi_rready   // Read ready
);
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end

	// Callers also write cancel outside execution and clear it after a command ends
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			s_axi_awvalid <= !ta;
			s_axi_wvalid <= !tw;
		end while (!(ta && tw));
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : cbs_host
`default_nettype wire

// ### tb/test_cbs_ctrl.sv
// Self-checking bench for the buffer state control block
`timescale 1ns/100ps
`default_nettype none
module test_cbs_ctrl;
	import cbs_pkg::*;
	localparam int CC = 16;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        init_event, locality_change, seize, cmd_write_seen, exec_done, exec_canceled;
	logic        fatal_error, exec_start, exec_cancel, buf_invalidate, resp_canceled;
	cbs_state_t  state, bp_state;
	int          n_errors = 0, tests_run = 0, cyc = 0, seed = 32'hdd0691c5;
	int          mst, mfat, mcan;

	cbs_ctrl #(.CANCEL_CYCLES(CC)) u_cbs_ctrl (.*);
	// Bypass-capable twin sees the same stimulus; only its state is watched
	cbs_ctrl #(.CANCEL_CYCLES(CC), .IDLE_BYPASS_CAPABLE(1'b1)) u_cbs_ctrl_bp (.*,
		.s_axi_awready(), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
		.s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
		.exec_start(), .exec_cancel(), .buf_invalidate(), .resp_canceled(),
		.state(bp_state));
	cbs_host u_cbs_host (.*);

	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			end_of_test;
		end
	end

	task automatic end_of_test;
		$display("errors %0d, checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// Expected register contents once request bits have settled
	function automatic logic [31:0] mdl(input logic [7:0] a);
		case (a)
			OFS_STS:    return {30'h0, mst == ST_IDLE, mfat[0]};
			OFS_CANCEL: return mcan;
			OFS_START:  return {31'h0, mst == ST_EXECUTION};
			default:    return 32'h0;
		endcase
	endfunction : mdl

	task automatic look(input logic [7:0] a);
		u_cbs_host.rd(a, v, r);
		chk(v, mdl(a));
		chk({30'h0, r}, {30'h0, (a > OFS_INTF_ID) ? RESP_DECERR : RESP_OKAY});
	endtask : look

	task automatic scan;
		for (int a = 0; a <= 16; a += 4)
			look(a[7:0]);
		chk({29'h0, state}, mst);
	endtask : scan

	task automatic put(input logic [7:0] a, input logic [31:0] d);
		repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
		u_cbs_host.wr(a, d, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : put

	task automatic wait_st(input cbs_state_t s);
		int k;
		k = 0;
		while (state !== s && k < 4 * CC + 40) begin
			@(posedge aclk);
			k++;
		end
		mst = s;
	endtask : wait_st

	// Start in Ready must be ignored before reception makes it count
	task automatic go_exec;
		put(OFS_REQ, 32'h1);
		put(OFS_START, START_GO);
		@(posedge aclk) cmd_write_seen <= 1'b1;
		@(posedge aclk) cmd_write_seen <= 1'b0;
		put(OFS_START, START_GO);
		mst = ST_EXECUTION;
	endtask : go_exec

	initial begin
		{init_event, locality_change, seize, cmd_write_seen} = '0;
		{exec_done, exec_canceled, fatal_error} = '0;
		mst = ST_IDLE;
		mfat = 0;
		mcan = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		scan;
		look(8'h40);
		put(OFS_STS, 32'hFFFF_FFFF);
		look(OFS_STS);
		mcan = $random(seed);
		put(OFS_CANCEL, mcan);
		scan;
		mcan = 0;
		put(OFS_CANCEL, REG_ZERO);
		put(OFS_REQ, REG_ZERO);
		scan;
		go_exec;
		scan;
		put(OFS_REQ, 32'h2);
		put(OFS_REQ, 32'h1);
		scan;
		@(posedge aclk) exec_done <= 1'b1;
		@(posedge aclk) exec_done <= 1'b0;
		wait_st(ST_COMPLETION);
		scan;
		chk({31'h0, resp_canceled}, 32'h0);
		put(OFS_REQ, 32'h1);
		put(OFS_REQ, 32'h1);
		chk({29'h0, bp_state}, ST_READY);
		scan;
		put(OFS_REQ, 32'h2);
		mst = ST_IDLE;
		scan;
		go_exec;
		mcan = 1;
		put(OFS_CANCEL, CANCEL_ON);
		wait_st(ST_COMPLETION);
		scan;
		chk({31'h0, resp_canceled}, 32'h1);
		mcan = 0;
		put(OFS_CANCEL, REG_ZERO);
		put(OFS_REQ, 32'h2);
		go_exec;
		@(posedge aclk) seize <= 1'b1;
		@(posedge aclk) seize <= 1'b0;
		wait_st(ST_IDLE);
		scan;
		put(OFS_REQ, 32'h1);
		@(posedge aclk) locality_change <= 1'b1;
		@(posedge aclk) locality_change <= 1'b0;
		wait_st(ST_IDLE);
		scan;
		@(posedge aclk) fatal_error <= 1'b1;
		@(posedge aclk) fatal_error <= 1'b0;
		mfat = 1;
		put(OFS_REQ, 32'h1);
		mst = ST_READY;
		scan;
		@(posedge aclk) init_event <= 1'b1;
		@(posedge aclk) init_event <= 1'b0;
		mst = ST_IDLE;
		mfat = 0;
		scan;
		end_of_test;
	end
endmodule : test_cbs_ctrl

bind cbs_ctrl cbs_monitor #(.CANCEL_CYCLES(CANCEL_CYCLES)) u_cbs_monitor (.*);
`default_nettype wire
